// ===== design/tag_afi_data_storage_format_id_lock_cmds.v
// packet interpreter for identifier lock/write and block security status
// assumes byte streams on the core clock; tag access is a request/answer port
//
// Contract
// - the reader frames responses as start 01, length, node, flags, 60, data, checksum.
// - an error response carries the flags byte and exactly one error code.
// - a good write or lock response carries only the flags byte.
// - a good status response carries flags then one status byte per block.
// - error codes are 01 not found through 07 unsupported function and 0f undefined.
`default_nettype none
`include "tag_cmd_defines.vh"
module tag_afi_data_storage_format_id_lock_cmds (
  input  wire        CORE_CLK_I,
  input  wire        RST_N_I,
  input  wire        RX_VALID_I,
  input  wire [7:0]  RX_DATA_I,
  output wire        RX_READY_O,
  output reg         TX_VALID_O,
  output reg  [7:0]  TX_DATA_O,
  output reg         TX_LAST_O,
  input  wire        TX_READY_I,
  output reg         TAG_REQ_O,
  output reg  [7:0]  TAG_CODE_O,
  output reg  [7:0]  TAG_FLAGS_O,
  output reg  [63:0] TAG_UNIQUE_ID_O,
  output reg  [7:0]  TAG_ARG0_O,
  output reg  [7:0]  TAG_ARG1_O,
  input  wire        TAG_DONE_I,
  input  wire        TAG_ERR_I,
  input  wire [7:0]  TAG_ERR_CODE_I,
  input  wire [7:0]  TAG_STATUS_I,
  output reg  [7:0]  TAG_STATUS_IDX_O
);
  // ****************************************
  // states
  // ****************************************
  localparam [2:0] S_RX   = 3'h0;
  localparam [2:0] S_CK   = 3'h1;
  localparam [2:0] S_TAG  = 3'h2;
  localparam [2:0] S_TX   = 3'h3;
  localparam [2:0] S_DROP = 3'h4;

  reg  [2:0]  state_q;
  reg  [15:0] len_q;
  reg  [15:0] cnt_q;
  reg  [15:0] node_q;
  reg  [15:0] rx_sum_q;
  reg  [15:0] calc_q;
  reg         err_q;
  reg  [7:0]  err_code_q;
  reg  [7:0]  tx_idx_q;
  reg  [7:0]  tx_len_q;
  reg  [15:0] tx_sum_q;
  reg  [7:0]  tx_data_next;
  wire [15:0] sum_w;
  wire        rx_take = RX_VALID_I && (state_q == S_RX);
  wire        in_body = (cnt_q < len_q - 16'h0002);

  // dropped packets are still drained byte by byte so the host never stalls
  assign RX_READY_O = (state_q == S_RX) || (state_q == S_DROP);

  // request length implied by each code; zero marks an unsupported code
  function [7:0] req_len;
    input [7:0] code;
    begin
      case (code)
        `CODE_LOCK_AFI:    req_len = 8'h13;
        `CODE_WRITE_DATA_STORAGE_FORMAT_ID: req_len = 8'h13;
        `CODE_LOCK_DATA_STORAGE_FORMAT_ID:  req_len = 8'h12;
        `CODE_GET_SEC:     req_len = 8'h14;
        default:           req_len = 8'h00;
      endcase
    end
  endfunction

  // ****************************************
  // checksum over received bytes except the trailing pair
  // ****************************************
  pkt_checksum u_sum (
    .clk_i   (CORE_CLK_I),
    .rst_n_i (RST_N_I),
    .clear_i (state_q != S_RX),
    .en_i    (rx_take && in_body && !(cnt_q == 16'h0000 && RX_DATA_I != `PKT_SOF)),
    .byte_i  (RX_DATA_I),
    .sum_o   (sum_w)
  );

  // ****************************************
  // receive, check, tag access, respond
  // ****************************************
  always @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_q <= S_RX;
      len_q <= 16'hffff;
      cnt_q <= 16'h0000;
      node_q <= 16'h0000;
      rx_sum_q <= 16'h0000;
      calc_q <= 16'h0000;
      err_q <= 1'b0;
      err_code_q <= 8'h00;
      tx_idx_q <= 8'h00;
      tx_len_q <= 8'h00;
      tx_sum_q <= 16'h0000;
      TX_VALID_O <= 1'b0;
      TX_DATA_O <= 8'h00;
      TX_LAST_O <= 1'b0;
      TAG_REQ_O <= 1'b0;
      TAG_CODE_O <= 8'h00;
      TAG_FLAGS_O <= 8'h00;
      TAG_UNIQUE_ID_O <= 64'h0;
      TAG_ARG0_O <= 8'h00;
      TAG_ARG1_O <= 8'h00;
      TAG_STATUS_IDX_O <= 8'h00;
    end else begin
      case (state_q)
        S_RX: begin
          if (rx_take) begin
            cnt_q <= cnt_q + 16'h0001;
            case (cnt_q[4:0])
              5'h00: if (RX_DATA_I != `PKT_SOF) cnt_q <= 16'h0000;
              5'h01: len_q[15:8] <= RX_DATA_I;
              5'h02: len_q[7:0] <= RX_DATA_I;
              5'h03: node_q[15:8] <= RX_DATA_I;
              5'h04: node_q[7:0] <= RX_DATA_I;
              `FLAGS_POS: TAG_FLAGS_O <= RX_DATA_I;
              `CODE_POS: TAG_CODE_O <= RX_DATA_I;
              `ARG0_POS: TAG_ARG0_O <= RX_DATA_I;
              `ARG1_POS: TAG_ARG1_O <= RX_DATA_I;
              default: begin
              end
            endcase
            if (cnt_q >= {11'h0, `UID_POS} && cnt_q < {11'h0, `ARG0_POS} && cnt_q[15:5] == 11'h0) begin
              TAG_UNIQUE_ID_O <= {TAG_UNIQUE_ID_O[55:0], RX_DATA_I};
            end
            if (cnt_q == 16'h0006 && RX_DATA_I != `PKT_CMD) begin
              state_q <= S_DROP;
            end
            if (!in_body) begin
              rx_sum_q <= {rx_sum_q[7:0], RX_DATA_I};
            end
            if (cnt_q == len_q - 16'h0001) begin
              state_q <= S_CK;
              calc_q <= sum_w;
            end
          end
        end
        S_CK: begin
          cnt_q <= 16'h0000;
          len_q <= 16'hffff;
          err_q <= 1'b1;
          tx_idx_q <= 8'h00;
          if (rx_sum_q != calc_q) begin
            err_code_q <= `ERR_BAD_CHECK;
            state_q <= S_TX;
          end else if (req_len(TAG_CODE_O) == 8'h00) begin
            err_code_q <= `ERR_UNSUPPORTED;
            state_q <= S_TX;
          end else if (len_q[7:0] != req_len(TAG_CODE_O) + 8'h02 || len_q[15:8] != 8'h00) begin
            err_code_q <= `ERR_UNDEFINED;
            state_q <= S_TX;
          end else if (TAG_CODE_O == `CODE_GET_SEC && TAG_ARG1_O >= `MAX_BLOCKS) begin
            err_code_q <= `ERR_BAD_FLAGS;
            state_q <= S_TX;
          end else begin
            TAG_REQ_O <= 1'b1;
            TAG_STATUS_IDX_O <= 8'h00;
            state_q <= S_TAG;
          end
          // total bytes: header, flags, error code, checksum pair
          tx_len_q <= `HDR_BYTES + 8'h04;
        end
        S_TAG: begin
          if (TAG_DONE_I) begin
            TAG_REQ_O <= 1'b0;
            err_q <= TAG_ERR_I;
            err_code_q <= TAG_ERR_CODE_I;
            state_q <= S_TX;
            if (TAG_ERR_I) begin
              tx_len_q <= `HDR_BYTES + 8'h04;
            end else if (TAG_CODE_O == `CODE_GET_SEC) begin
              tx_len_q <= `HDR_BYTES + 8'h04 + TAG_ARG1_O;
            end else begin
              tx_len_q <= `HDR_BYTES + 8'h03;
            end
          end
        end
        S_TX: begin
          // one byte per accepted beat; data held until taken
          if (!TX_VALID_O || TX_READY_I) begin
            if (tx_idx_q == tx_len_q) begin
              TX_VALID_O <= 1'b0;
              TX_LAST_O <= 1'b0;
              tx_idx_q <= 8'h00;
              state_q <= S_RX;
            end else begin
              TX_VALID_O <= 1'b1;
              TX_LAST_O <= (tx_idx_q == tx_len_q - 8'h01);
              tx_idx_q <= tx_idx_q + 8'h01;
              if (tx_idx_q < tx_len_q - 8'h02) begin
                tx_sum_q <= (tx_idx_q == 8'h00) ? {~tx_data_next, tx_data_next}
                           : {~(tx_sum_q[7:0] ^ tx_data_next), tx_sum_q[7:0] ^ tx_data_next};
              end
              TX_DATA_O <= tx_data_next;
              if (tx_idx_q >= `HDR_BYTES) begin
                TAG_STATUS_IDX_O <= tx_idx_q - `HDR_BYTES;
              end
            end
          end
        end
        S_DROP: begin
          // discard rest of a foreign packet
          if (RX_VALID_I) begin
            cnt_q <= cnt_q + 16'h0001;
          end
          if (RX_VALID_I && cnt_q == len_q - 16'h0001) begin
            cnt_q <= 16'h0000;
            len_q <= 16'hffff;
            state_q <= S_RX;
          end
        end
        default: state_q <= S_RX;
      endcase
    end
  end

  // ****************************************
  // response byte selection
  // ****************************************
  always @* begin
    tx_data_next = 8'h00;
    case (tx_idx_q)
      8'h00: tx_data_next = `PKT_SOF;
      8'h01: tx_data_next = 8'h00;
      8'h02: tx_data_next = tx_len_q;
      8'h03: tx_data_next = node_q[15:8];
      8'h04: tx_data_next = node_q[7:0];
      8'h05: tx_data_next = err_q ? `RSP_FLAG_ERR : 8'h00;
      8'h06: tx_data_next = `PKT_CMD;
      8'h07: tx_data_next = err_q ? `RSP_FLAG_ERR : 8'h00;
      default: begin
        if (tx_idx_q == tx_len_q - 8'h02) begin
          tx_data_next = tx_sum_q[15:8];
        end else if (tx_idx_q == tx_len_q - 8'h01) begin
          tx_data_next = tx_sum_q[7:0];
        end else if (err_q) begin
          tx_data_next = err_code_q;
        end else begin
          tx_data_next = TAG_STATUS_I;
        end
      end
    endcase
  end
endmodule // tag_afi_data_storage_format_id_lock_cmds
`default_nettype wire

// ===== design/tag_cmd_defines.vh
// constants for the tag identifier lock / security status packet interpreter
// assumes inclusion by bare name from design files
`ifndef TAG_CMD_DEFINES_VH
`define TAG_CMD_DEFINES_VH
`define PKT_SOF          8'h01
`define PKT_CMD          8'h60
`define CODE_LOCK_AFI    8'h28
`define CODE_WRITE_DATA_STORAGE_FORMAT_ID 8'h29
`define CODE_LOCK_DATA_STORAGE_FORMAT_ID  8'h2a
`define CODE_GET_SEC     8'h2c
`define ERR_NOT_FOUND    8'h01
`define ERR_UNSUPPORTED  8'h02
`define ERR_BAD_CHECK    8'h03
`define ERR_BAD_FLAGS    8'h04
`define ERR_WRITE_FAIL   8'h05
`define ERR_LOCKED       8'h06
`define ERR_NO_FUNC      8'h07
`define ERR_UNDEFINED    8'h0f
`define RSP_FLAG_ERR     8'h01
`define UID_BYTES        4'h8
`define HDR_BYTES        5'h07
`define CFG_POS          5'h07
`define FLAGS_POS        5'h08
`define CODE_POS         5'h09
`define UID_POS          5'h0a
`define ARG0_POS         5'h12
`define ARG1_POS         5'h13
`define MAX_BLOCKS       8'h3d
`endif

// ===== design/pkt_checksum.v
// running checksum over packet bytes: xor in low byte, inverted xor in high
// assumes byte strobes on the core clock; clear before each packet
`default_nettype none
module pkt_checksum (
  input  wire        clk_i,
  input  wire        rst_n_i,
  input  wire        clear_i,
  input  wire        en_i,
  input  wire [7:0]  byte_i,
  output reg  [15:0] sum_o
);
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sum_o <= 16'h0000;
    end else if (clear_i) begin
      sum_o <= 16'h0000;
    end else if (en_i) begin
      // high byte is the inverse of the running xor, not an alternating fold
      sum_o <= {~(sum_o[7:0] ^ byte_i), sum_o[7:0] ^ byte_i};
    end
  end
endmodule // pkt_checksum
`default_nettype wire

// ===== tb/tag_cmd_asserts.sv
// port checker for the packet interpreter
// assumes a bind onto the top module
`default_nettype none
module tag_cmd_asserts (
  input wire logic       CORE_CLK_I,
  input wire logic       RST_N_I,
  input wire logic       RX_READY_O,
  input wire logic       TX_VALID_O,
  input wire logic [7:0] TX_DATA_O,
  input wire logic       TX_LAST_O,
  input wire logic       TX_READY_I,
  input wire logic       TAG_REQ_O,
  input wire logic [7:0] TAG_CODE_O,
  input wire logic [7:0] TAG_ARG1_O,
  input wire logic       TAG_DONE_I
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // response byte position
  // ****
  logic [7:0] pos_q;
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_N_I);
  always @(posedge CORE_CLK_I or negedge RST_N_I)
    if (!RST_N_I) pos_q <= 8'h00;
    else if (TX_VALID_O && TX_READY_I) pos_q <= TX_LAST_O ? 8'h00 : pos_q + 8'h01;
  sof_first_a: assert property (pos_q == 8'h00 && TX_VALID_O |-> TX_DATA_O == 8'h01)
    else $error("response does not open with start byte");
  len_high_a: assert property (pos_q == 8'h01 && TX_VALID_O |-> TX_DATA_O == 8'h00)
    else $error("length high byte not zero");
  cmd_byte_a: assert property (pos_q == 8'h06 && TX_VALID_O |-> TX_DATA_O == 8'h60)
    else $error("command byte missing");
  tx_hold_a: assert property (TX_VALID_O && !TX_READY_I |=> TX_VALID_O && $stable(TX_DATA_O) && $stable(TX_LAST_O))
    else $error("tx byte changed before accept");
  last_gap_a: assert property (TX_VALID_O && TX_READY_I && TX_LAST_O |=> !TX_VALID_O)
    else $error("byte after last");
  req_code_a: assert property ($rose(TAG_REQ_O) |-> TAG_CODE_O inside {8'h28, 8'h29, 8'h2a, 8'h2c})
    else $error("tag request with unsupported code");
  sec_count_a: assert property (TAG_REQ_O && TAG_CODE_O == 8'h2c |-> TAG_ARG1_O < 8'h3d)
    else $error("block count beyond limit reached tag");
  req_hold_a: assert property (TAG_REQ_O && !TAG_DONE_I |=> TAG_REQ_O && $stable(TAG_CODE_O))
    else $error("tag request dropped early");
  answer_a: assert property (TAG_REQ_O && TAG_DONE_I |-> ##[1:3] TX_VALID_O)
    else $error("no response after tag done");
  rx_quiet_a: assert property (TX_VALID_O || TAG_REQ_O |-> !RX_READY_O)
    else $error("receiving while busy");
  cover property ($rose(TAG_REQ_O));
  cover property (TX_VALID_O && TX_READY_I && TX_LAST_O);
  cover property (TX_VALID_O && !TX_READY_I);
endmodule // tag_cmd_asserts
`default_nettype wire

// ===== tb/tag_responder.sv
// tag side model: answers each request with a one-cycle done
// assumes request held until done, status looked up by index
`default_nettype none
module tag_responder (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       req_i,
  input  wire logic [7:0] idx_i,
  input  wire logic       fail_i,
  input  wire logic [7:0] code_i,
  input  wire logic [3:0] lat_i,
  output var  logic       done_o,
  output wire logic       err_o,
  output wire logic [7:0] err_code_o,
  output wire logic [7:0] status_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_q;
  logic       busy_q;
  assign status_o = idx_i ^ 8'h5a;
  // junk outside done so a stale sample shows
  assign err_o = done_o ? fail_i : ~fail_i;
  assign err_code_o = done_o ? code_i : ~code_i;
  always @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i) begin
      done_o <= 1'b0;
      busy_q <= 1'b0;
      wait_q <= 4'h0;
    end else begin
      done_o <= 1'b0;
      if (!req_i) begin
        busy_q <= 1'b0;
        wait_q <= 4'h0;
      end else if (!busy_q && wait_q == lat_i) begin
        done_o <= 1'b1;
        busy_q <= 1'b1;
      end else if (!busy_q) wait_q <= wait_q + 4'h1;
    end
endmodule // tag_responder
`default_nettype wire

// ===== tb/tag_afi_data_storage_format_id_lock_cmds_bench.sv
// self-checking bench: host packets in, response bytes compared
// assumes the tag responder model and the port checker
`default_nettype none
module tag_afi_data_storage_format_id_lock_cmds_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_n, rx_valid, tx_ready, fail, done, terr, rx_ready, tx_valid, tx_last, req;
  logic [7:0]  rx_data, ecode, terr_code, status, tx_data, idx;
  logic [3:0]  lat;
  logic [31:0] rnd, rs;
  logic [8:0]  exp_q[$];
  int          fail_count, checks, cyc;
  tag_afi_data_storage_format_id_lock_cmds i_dut (.CORE_CLK_I(clk), .RST_N_I(rst_n), .RX_VALID_I(rx_valid), .RX_DATA_I(rx_data),
    .RX_READY_O(rx_ready), .TX_VALID_O(tx_valid), .TX_DATA_O(tx_data), .TX_LAST_O(tx_last), .TX_READY_I(tx_ready),
    .TAG_REQ_O(req), .TAG_CODE_O(), .TAG_FLAGS_O(), .TAG_UNIQUE_ID_O(), .TAG_ARG0_O(), .TAG_ARG1_O(),
    .TAG_DONE_I(done), .TAG_ERR_I(terr), .TAG_ERR_CODE_I(terr_code), .TAG_STATUS_I(status), .TAG_STATUS_IDX_O(idx));
  tag_responder i_tag (.clk_i(clk), .rst_n_i(rst_n), .req_i(req), .idx_i(idx), .fail_i(fail), .code_i(ecode),
    .lat_i(lat), .done_o(done), .err_o(terr), .err_code_o(terr_code), .status_o(status));
  function automatic logic [31:0] step(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic final_report();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [8:0] got, input logic [8:0] want);
    checks++;
    if (got !== want) begin
      fail_count++;
      $display("Error at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic send(input logic [7:0] b);
    rx_data = b;
    rx_valid = 1'b1;
    while (!rx_ready) @(posedge clk) #1;
    @(posedge clk) #1;
  endtask
  // ****
  // one request packet, expected reply queued first
  // ****
  task automatic pkt(input logic [7:0] c, input logic [7:0] a1, input logic bad, input logic tf, input logic [7:0] err);
    logic [7:0] b[$];
    logic [7:0] r[$];
    logic [7:0] x, n;
    rnd = step(rnd);
    fail = tf;
    ecode = err;
    lat = rnd[3:0];
    n = (c == 8'h2c && err == 8'h00) ? a1 + 8'h01 : 8'h00;
    b = {8'h01, 8'h00, 8'h15, rnd[15:8], rnd[7:0], 8'h00, 8'h60, 8'h00, rnd[23:16], c};
    if (c == 8'h2a) b[2] = 8'h14;
    if (c == 8'h2c) b[2] = 8'h16;
    for (int i = 0; i < 8; i++) b.push_back(rnd[31:24] + 8'(i));
    if (c != 8'h2a) b.push_back((c == 8'h2c) ? 8'h00 : rnd[27:20]);
    if (c == 8'h2c) b.push_back(a1);
    r = {8'h01, 8'h00, 8'h0a + n + 8'(err != 8'h00), rnd[15:8], rnd[7:0], 8'(err != 8'h00), 8'h60, 8'(err != 8'h00)};
    if (err != 8'h00) r.push_back(err);
    for (int k = 0; k < int'(n); k++) r.push_back(8'(k) ^ 8'h5a);
    x = 8'h00;
    foreach (r[i]) x ^= r[i];
    r.push_back(~x);
    r.push_back(x);
    foreach (r[i]) exp_q.push_back({i == r.size() - 1, r[i]});
    x = bad ? 8'h5a : 8'h00;
    foreach (b[i]) x ^= b[i];
    b.push_back(~x);
    b.push_back(x);
    foreach (b[i]) send(b[i]);
    rx_valid = 1'b0;
    rx_data = ~x;
    wait (exp_q.size() == 0);
    repeat (3) @(posedge clk);
    #1;
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) #1 begin
    rs = step(rs);
    tx_ready = rs[0] | rs[1];
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      final_report();
    end
    if (rst_n && tx_valid && tx_ready) cmp({tx_last, tx_data}, exp_q.size() ? exp_q.pop_front() : 9'h1ff);
  end
  initial begin
    logic [7:0] codes[4] = '{8'h28, 8'h29, 8'h2a, 8'h2c};
    logic [7:0] errs[4] = '{8'h01, 8'h05, 8'h06, 8'h07};
    rnd = 32'h6254;
    rs = 32'h6254;
    {rst_n, rx_valid, rx_data, fail, ecode, lat} = '0;
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    for (int j = 0; j < 3; j++)
      foreach (codes[i]) pkt(codes[i], j == 2 ? 8'h3c : {5'h0, rnd[2:0]}, 1'b0, j == 1, j == 1 ? errs[i] : 8'h00);
    // foreign command byte: silently drained, the next reply proves recovery
    for (int i = 0; i < 21; i++) send(i == 0 ? 8'h01 : i == 2 ? 8'h15 : i < 5 ? 8'h00 : 8'h61);
    rx_valid = 1'b0;
    pkt(8'h2c, 8'h07, 1'b0, 1'b1, 8'h0f);
    pkt(8'h2c, 8'h3d, 1'b0, 1'b0, 8'h04);
    pkt(8'h22, 8'h00, 1'b0, 1'b0, 8'h02);
    pkt(8'h29, 8'h00, 1'b1, 1'b0, 8'h03);
    final_report();
  end
endmodule // tag_afi_data_storage_format_id_lock_cmds_bench
bind tag_afi_data_storage_format_id_lock_cmds tag_cmd_asserts i_chk (.CORE_CLK_I(CORE_CLK_I), .RST_N_I(RST_N_I),
  .RX_READY_O(RX_READY_O), .TX_VALID_O(TX_VALID_O), .TX_DATA_O(TX_DATA_O), .TX_LAST_O(TX_LAST_O),
  .TX_READY_I(TX_READY_I), .TAG_REQ_O(TAG_REQ_O), .TAG_CODE_O(TAG_CODE_O), .TAG_ARG1_O(TAG_ARG1_O),
  .TAG_DONE_I(TAG_DONE_I));
`default_nettype wire
